// file: core/mscfl_pkg.sv
// constants for the meter, snapshot and fault-log control registers
// Summary of operation
// - meter clear holds energy and ticks zero
// - meter freeze stops energy and tick adding
// - tick counter overflow sets tick wrap flag
// - energy overflow sets energy wrap flag
// - alert sets latch, host write of zero clears it
// - lock bit is read-only factory lock status
// - reserved bits ignore writes, read zero
// - channel field picks one of fourteen inputs, codes A and B refused
// - snapshot bit: one-shot mode, else continuous
// - armed capture copies log on fault
// - capture flags clear only under permit
// - begun flag set by device, host clears
// - finished flag set by device, host clears
// - alert enable raises alert on finish
// - fault and alarm bytes go to A4-A9
// - current msb bytes go to E1-E3
// - voltage msb bytes go to E4-E6
// - tick counter counts accumulated cycles, 32 bits
// - energy is 48-bit, host readable and writable
package mscfl_pkg;
  // register byte addresses
  localparam logic [7:0] MSCFL_ADDR_METER = 8'h84;
  localparam logic [7:0] MSCFL_ADDR_SNAP = 8'h85;
  localparam logic [7:0] MSCFL_ADDR_LOG = 8'h90;
  localparam logic [7:0] MSCFL_ADDR_ENERGY = 8'h7A;
  localparam logic [7:0] MSCFL_ADDR_TICK = 8'h80;
  // meter control fields
  localparam int MSCFL_MC_CLEAR = 7;
  localparam int MSCFL_MC_FREEZE = 6;
  localparam int MSCFL_MC_CWRAP = 5;
  localparam int MSCFL_MC_AWRAP = 4;
  localparam int MSCFL_MC_ALERT = 3;
  localparam int MSCFL_MC_LOCK = 2;
  // snapshot fields
  localparam int MSCFL_SS_SEL_LO = 4;
  localparam int MSCFL_SS_MODE = 3;
  localparam logic [3:0] MSCFL_SEL_RSV_A = 4'hA;
  localparam logic [3:0] MSCFL_SEL_RSV_B = 4'hB;
  // fault-log control fields
  localparam int MSCFL_FL_ARM = 7;
  localparam int MSCFL_FL_PERMIT = 6;
  localparam int MSCFL_FL_BEGUN = 5;
  localparam int MSCFL_FL_DONE = 4;
  localparam int MSCFL_FL_AEN = 3;
  // widths of meter state
  localparam int MSCFL_ACC_W = 48;
  localparam int MSCFL_CNT_W = 32;
  localparam int MSCFL_PWR_W = 24;
  localparam logic [2:0] MSCFL_ACC_BYTES = 3'h6;
  localparam logic [2:0] MSCFL_CNT_BYTES = 3'h4;
  // nonvolatile capture layout
  localparam logic [7:0] MSCFL_NVM_FAULT = 8'hA4;
  localparam logic [7:0] MSCFL_NVM_ADC = 8'hE1;
  localparam logic [3:0] MSCFL_NVM_SPLIT = 4'h6;
  localparam logic [3:0] MSCFL_NVM_LAST = 4'hB;
  localparam int MSCFL_LOG_W = 96;
  // capture sequencer states
  typedef enum logic [2:0] {
    MSCFL_IDLE = 3'b001,
    MSCFL_SEND = 3'b010,
    MSCFL_FIN = 3'b100
  } mscfl_state_t;
endpackage

// file: core/mscfl_meter_if.sv
// signals between the register logic and the meter core
`timescale 1ns/10ps
interface mscfl_meter_if;
  import mscfl_pkg::*;
  logic clear; // hold both at zero
  logic freeze; // stop accumulation
  logic add_en; // one power result ready
  logic [MSCFL_PWR_W-1:0] add_val; // power result
  logic wr_en; // host byte write
  logic wr_tick; // 1 = tick counter, 0 = energy
  logic [2:0] wr_idx; // byte index, 0 = most significant
  logic [7:0] wr_data; // byte written
  logic [MSCFL_ACC_W-1:0] energy; // accumulated energy
  logic [MSCFL_CNT_W-1:0] ticks; // accumulated cycles
  logic acc_wrap; // energy overflow pulse
  logic cnt_wrap; // tick overflow pulse
  modport ctl (output clear, freeze, add_en, add_val, wr_en, wr_tick, wr_idx, wr_data,
               input energy, ticks, acc_wrap, cnt_wrap);
  modport mtr (input clear, freeze, add_en, add_val, wr_en, wr_tick, wr_idx, wr_data,
               output energy, ticks, acc_wrap, cnt_wrap);
endinterface

// file: core/mscfl_meter.sv
// energy accumulator and tick counter core
`timescale 1ns/10ps
module mscfl_meter
  import mscfl_pkg::*;
(
  input wire logic i_mclk, // system clock
  input wire logic i_rst_n, // async reset, active low
  mscfl_meter_if.mtr m // control and results
);
  ////////////////////////////////////////////////////////////////////
  logic [MSCFL_ACC_W-1:0] acc_r; // energy value
  logic [MSCFL_CNT_W-1:0] cnt_r; // tick count
  logic acc_wrap_r; // energy carry pulse
  logic cnt_wrap_r; // tick carry pulse
  wire [MSCFL_ACC_W:0] acc_sum; // energy plus power, with carry
  wire [MSCFL_CNT_W:0] cnt_sum; // tick plus one, with carry
  wire [5:0] acc_sh; // bit offset of written energy byte
  wire [4:0] cnt_sh; // bit offset of written tick byte
  wire [MSCFL_ACC_W-1:0] acc_wr; // energy after byte write
  wire [MSCFL_CNT_W-1:0] cnt_wr; // ticks after byte write
  wire go; // accumulate this cycle
  ////////////////////////////////////////////////////////////////////
  // arithmetic and byte merge
  assign acc_sum = {1'b0, acc_r} + {{(MSCFL_ACC_W+1-MSCFL_PWR_W){1'b0}}, m.add_val};
  assign cnt_sum = {1'b0, cnt_r} + {{MSCFL_CNT_W{1'b0}}, 1'b1};
  assign acc_sh = {3'(MSCFL_ACC_BYTES - 3'h1 - m.wr_idx), 3'h0};
  assign cnt_sh = {2'(MSCFL_CNT_BYTES - 3'h1 - m.wr_idx), 3'h0};
  assign acc_wr = (acc_r & ~({{(MSCFL_ACC_W-8){1'b0}}, 8'hFF} << acc_sh))
                | ({{(MSCFL_ACC_W-8){1'b0}}, m.wr_data} << acc_sh);
  assign cnt_wr = (cnt_r & ~({{(MSCFL_CNT_W-8){1'b0}}, 8'hFF} << cnt_sh))
                | ({{(MSCFL_CNT_W-8){1'b0}}, m.wr_data} << cnt_sh);
  assign go = m.add_en && !m.freeze;
  assign m.energy = acc_r;
  assign m.ticks = cnt_r;
  assign m.acc_wrap = acc_wrap_r;
  assign m.cnt_wrap = cnt_wrap_r;
  ////////////////////////////////////////////////////////////////////
  // clear wins, then host write, then accumulation
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_r <= '0;
      cnt_r <= '0;
      acc_wrap_r <= 1'b0;
      cnt_wrap_r <= 1'b0;
    end else if (m.clear) begin
      acc_r <= '0;
      cnt_r <= '0;
      acc_wrap_r <= 1'b0;
      cnt_wrap_r <= 1'b0;
    end else if (m.wr_en) begin
      acc_r <= m.wr_tick ? acc_r : acc_wr;
      cnt_r <= m.wr_tick ? cnt_wr : cnt_r;
      acc_wrap_r <= 1'b0;
      cnt_wrap_r <= 1'b0;
    end else begin
      acc_r <= go ? acc_sum[MSCFL_ACC_W-1:0] : acc_r;
      cnt_r <= go ? cnt_sum[MSCFL_CNT_W-1:0] : cnt_r;
      acc_wrap_r <= go && acc_sum[MSCFL_ACC_W];
      cnt_wrap_r <= go && cnt_sum[MSCFL_CNT_W];
    end
  end
  ////////////////////////////////////////////////////////////////////
  // checks
  a_freeze_keeps: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    m.freeze && !m.clear && !m.wr_en |=> $stable(acc_r) && $stable(cnt_r))
    else $error("meter moved while frozen");
  a_tick_advance: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    go && !m.clear && !m.wr_en |=> cnt_r == $past(cnt_r) + 32'h1)
    else $error("tick did not advance");
endmodule

// file: core/mscfl_ctrl.sv
// control and status registers for meter, snapshot and fault capture
`timescale 1ns/10ps
module mscfl_ctrl
  import mscfl_pkg::*;
(
  input wire logic i_mclk, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [7:0] i_reg_addr, // register address
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  input wire logic [7:0] i_reg_wdata, // write data
  output logic [7:0] o_reg_rdata, // read data, next cycle
  input wire logic i_alert_event, // some alert raised
  input wire logic i_nvm_factory_locked, // factory lock status
  input wire logic i_pwr_valid, // power result ready
  input wire logic [MSCFL_PWR_W-1:0] i_pwr_value, // power result
  input wire logic i_fault_trigger, // fault occurred
  input wire logic [7:0] i_fault_reg, // system fault byte
  input wire logic [39:0] i_alarm_log, // alarm bytes, first in top
  input wire logic [23:0] i_sense_msb, // latest, min, max current
  input wire logic [23:0] i_power_calc_voltage_msb, // latest, min, max
  output logic [3:0] o_snap_sel, // one-shot channel
  output logic o_snap_mode, // 1 one-shot, 0 continuous
  output logic o_nvm_req, // nvm byte write request
  output logic [7:0] o_nvm_addr, // nvm location
  output logic [7:0] o_nvm_data, // nvm byte
  input wire logic i_nvm_ack, // nvm took the byte
  output logic o_log_alert // capture finished alert pulse
);
  ////////////////////////////////////////////////////////////////////
  mscfl_meter_if mi (); // meter link
  mscfl_meter u_meter (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .m(mi.mtr)
  );
  ////////////////////////////////////////////////////////////////////
  // state
  logic clear_r; // meter clear
  logic freeze_r; // meter freeze
  logic cwrap_r; // tick wrap flag
  logic awrap_r; // energy wrap flag
  logic alert_r; // alert latch
  logic [3:0] sel_r; // channel field
  logic mode_r; // snapshot mode
  logic arm_r; // capture arm
  logic permit_r; // clear permit
  logic begun_r; // capture begun
  logic done_r; // capture finished
  logic aen_r; // finish alert enable
  mscfl_state_t st_r; // sequencer state
  mscfl_state_t st_nxt; // next state
  logic [3:0] idx_r; // byte being written
  logic [MSCFL_LOG_W-1:0] snap_r; // captured sources
  logic [7:0] rdata_r; // read data
  logic req_r; // nvm request
  logic [7:0] naddr_r; // nvm address
  logic [7:0] ndata_r; // nvm data
  logic lalert_r; // alert pulse
  ////////////////////////////////////////////////////////////////////
  // decode
  wire wr_meter = i_reg_wr && (i_reg_addr == MSCFL_ADDR_METER);
  wire wr_snap = i_reg_wr && (i_reg_addr == MSCFL_ADDR_SNAP);
  wire wr_log = i_reg_wr && (i_reg_addr == MSCFL_ADDR_LOG);
  wire [7:0] e_off = 8'(i_reg_addr - MSCFL_ADDR_ENERGY);
  wire [7:0] t_off = 8'(i_reg_addr - MSCFL_ADDR_TICK);
  wire in_e = e_off < {5'h0, MSCFL_ACC_BYTES};
  wire in_t = t_off < {5'h0, MSCFL_CNT_BYTES};
  wire [3:0] new_sel = i_reg_wdata[MSCFL_SS_SEL_LO +: 4];
  wire sel_ok = (new_sel != MSCFL_SEL_RSV_A) && (new_sel != MSCFL_SEL_RSV_B);
  wire can_clr = wr_log && permit_r;
  ////////////////////////////////////////////////////////////////////
  // meter link drive
  assign mi.clear = clear_r;
  assign mi.freeze = freeze_r;
  assign mi.add_en = i_pwr_valid;
  assign mi.add_val = i_pwr_value;
  assign mi.wr_en = i_reg_wr && (in_e || in_t);
  assign mi.wr_tick = in_t;
  assign mi.wr_idx = in_t ? t_off[2:0] : e_off[2:0];
  assign mi.wr_data = i_reg_wdata;
  ////////////////////////////////////////////////////////////////////
  // capture events
  wire start_go = (st_r == MSCFL_IDLE) && i_fault_trigger && arm_r
                  && !begun_r && !done_r;
  wire last_ack = (st_r == MSCFL_SEND) && i_nvm_ack && (idx_r == MSCFL_NVM_LAST);
  wire fin = st_r == MSCFL_FIN;
  wire fin_alert = fin && aen_r;
  ////////////////////////////////////////////////////////////////////
  // next capture byte
  wire [MSCFL_LOG_W-1:0] src = {i_fault_reg, i_alarm_log, i_sense_msb,
                                i_power_calc_voltage_msb};
  wire [MSCFL_LOG_W-1:0] bytes = start_go ? src : snap_r;
  wire [3:0] nidx = start_go ? 4'h0 : 4'(idx_r + 4'h1);
  wire [6:0] nsh = {4'(MSCFL_NVM_LAST - nidx), 3'h0};
  wire [7:0] nbyte = 8'(bytes >> nsh);
  wire lo_area = nidx < MSCFL_NVM_SPLIT;
  wire [7:0] nloc = lo_area ? 8'(MSCFL_NVM_FAULT + {4'h0, nidx})
                  : 8'(MSCFL_NVM_ADC + {4'h0, 4'(nidx - MSCFL_NVM_SPLIT)});
  wire load = start_go || ((st_r == MSCFL_SEND) && i_nvm_ack && !last_ack);
  ////////////////////////////////////////////////////////////////////
  // read mux
  wire [7:0] rd_meter = {clear_r, freeze_r, cwrap_r, awrap_r, alert_r,
                         i_nvm_factory_locked, 2'b00};
  wire [7:0] rd_snap = {sel_r, mode_r, 3'b000};
  wire [7:0] rd_log = {arm_r, permit_r, begun_r, done_r, aen_r, 3'b000};
  wire [5:0] e_sh = {3'(MSCFL_ACC_BYTES - 3'h1 - e_off[2:0]), 3'h0};
  wire [4:0] t_sh = {2'(MSCFL_CNT_BYTES - 3'h1 - t_off[2:0]), 3'h0};
  wire [7:0] rd_e = 8'(mi.energy >> e_sh);
  wire [7:0] rd_t = 8'(mi.ticks >> t_sh);
  wire [7:0] rd_val = (i_reg_addr == MSCFL_ADDR_METER) ? rd_meter
                    : (i_reg_addr == MSCFL_ADDR_SNAP) ? rd_snap
                    : (i_reg_addr == MSCFL_ADDR_LOG) ? rd_log
                    : in_e ? rd_e
                    : in_t ? rd_t
                    : 8'h00;
  ////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    case (st_r)
      MSCFL_IDLE: begin
        st_nxt = start_go ? MSCFL_SEND : MSCFL_IDLE;
      end
      MSCFL_SEND: begin
        st_nxt = last_ack ? MSCFL_FIN : MSCFL_SEND;
      end
      MSCFL_FIN: begin
        st_nxt = MSCFL_IDLE;
      end
      default: begin
        st_nxt = MSCFL_IDLE;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////
  // meter control, set beats clear on flags
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clear_r <= 1'b0;
      freeze_r <= 1'b0;
      cwrap_r <= 1'b0;
      awrap_r <= 1'b0;
      alert_r <= 1'b0;
    end else begin
      clear_r <= wr_meter ? i_reg_wdata[MSCFL_MC_CLEAR] : clear_r;
      freeze_r <= wr_meter ? i_reg_wdata[MSCFL_MC_FREEZE] : freeze_r;
      cwrap_r <= mi.cnt_wrap
                 || (cwrap_r && !(wr_meter && !i_reg_wdata[MSCFL_MC_CWRAP]));
      awrap_r <= mi.acc_wrap
                 || (awrap_r && !(wr_meter && !i_reg_wdata[MSCFL_MC_AWRAP]));
      alert_r <= i_alert_event || fin_alert
                 || (alert_r && !(wr_meter && !i_reg_wdata[MSCFL_MC_ALERT]));
    end
  end
  ////////////////////////////////////////////////////////////////////
  // snapshot register, reserved codes refused
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_r <= 4'h0;
      mode_r <= 1'b0;
    end else if (wr_snap) begin
      sel_r <= sel_ok ? new_sel : sel_r;
      mode_r <= i_reg_wdata[MSCFL_SS_MODE];
    end
  end
  ////////////////////////////////////////////////////////////////////
  // fault-log control
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arm_r <= 1'b0;
      permit_r <= 1'b0;
      aen_r <= 1'b0;
      begun_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      arm_r <= wr_log ? i_reg_wdata[MSCFL_FL_ARM] : arm_r;
      permit_r <= wr_log ? i_reg_wdata[MSCFL_FL_PERMIT] : permit_r;
      aen_r <= wr_log ? i_reg_wdata[MSCFL_FL_AEN] : aen_r;
      begun_r <= start_go
                 || (begun_r && !(can_clr && !i_reg_wdata[MSCFL_FL_BEGUN]));
      done_r <= fin
                || (done_r && !(can_clr && !i_reg_wdata[MSCFL_FL_DONE]));
    end
  end
  ////////////////////////////////////////////////////////////////////
  // capture sequencer and nvm port
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= MSCFL_IDLE;
      idx_r <= 4'h0;
      snap_r <= '0;
      req_r <= 1'b0;
      naddr_r <= 8'h00;
      ndata_r <= 8'h00;
      lalert_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      snap_r <= start_go ? src : snap_r;
      idx_r <= load ? nidx : idx_r;
      naddr_r <= load ? nloc : naddr_r;
      ndata_r <= load ? nbyte : ndata_r;
      req_r <= load || (req_r && !last_ack);
      lalert_r <= fin_alert;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= 8'h00;
    end else if (i_reg_rd) begin
      rdata_r <= rd_val;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // outputs
  assign o_reg_rdata = rdata_r;
  assign o_snap_sel = sel_r;
  assign o_snap_mode = mode_r;
  assign o_nvm_req = req_r;
  assign o_nvm_addr = naddr_r;
  assign o_nvm_data = ndata_r;
  assign o_log_alert = lalert_r;
  ////////////////////////////////////////////////////////////////////
  // checks
  a_clear_zeroes: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    clear_r [*2] |-> mi.energy == '0 && mi.ticks == '0)
    else $error("meter not held at zero");
  a_tick_wrap: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    mi.cnt_wrap |=> cwrap_r)
    else $error("tick wrap flag missed");
  a_energy_wrap: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    mi.acc_wrap |=> awrap_r)
    else $error("energy wrap flag missed");
  a_alert_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    alert_r && !wr_meter |=> alert_r)
    else $error("alert latch dropped");
  a_lock_reads: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr == MSCFL_ADDR_METER
    |=> o_reg_rdata[MSCFL_MC_LOCK] == $past(i_nvm_factory_locked)
        && o_reg_rdata[1:0] == 2'b00)
    else $error("lock bit misread");
  a_rsvd_log: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr == MSCFL_ADDR_LOG |=> o_reg_rdata[2:0] == 3'b000)
    else $error("reserved bits not zero");
  a_snap_mode: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    wr_snap |=> o_snap_mode == $past(i_reg_wdata[MSCFL_SS_MODE]))
    else $error("snapshot mode not stored");
  a_permit_guard: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    begun_r && !permit_r |=> begun_r)
    else $error("begun cleared without permit");
  a_start_first: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    start_go |=> begun_r && o_nvm_req && o_nvm_addr == MSCFL_NVM_FAULT)
    else $error("capture start wrong");
  a_no_restart: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (begun_r || done_r) && (st_r == MSCFL_IDLE) |=> !o_nvm_req)
    else $error("capture restarted");
  a_finish_alert: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    last_ack |=> ##1 done_r && o_log_alert == $past(aen_r) && !o_nvm_req)
    else $error("finish flag or alert wrong");
  a_last_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    last_ack |-> o_nvm_addr == 8'(MSCFL_NVM_ADC + {4'h0, MSCFL_NVM_LAST - MSCFL_NVM_SPLIT}))
    else $error("last nvm address wrong");
  // capture flags, only hardware sets, only a permitted write clears
  a_done_guard: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    done_r && !permit_r |=> done_r)
    else $error("done cleared without permit");
  a_begun_no_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !begun_r && !start_go |=> !begun_r)
    else $error("begun set without capture");
  a_done_no_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !done_r && !fin |=> !done_r)
    else $error("done set without finish");
  a_arm_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    arm_r && !wr_log |=> arm_r)
    else $error("arm dropped without write");
  a_log_alert_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    fin_alert |=> alert_r && o_log_alert)
    else $error("finish alert not raised");
  a_alert_sets: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_alert_event |=> alert_r)
    else $error("alert latch not set");
  // snapshot register checks
  a_rsvd_snap: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr == MSCFL_ADDR_SNAP |=> o_reg_rdata[2:0] == 3'b000)
    else $error("snapshot reserved bits not zero");
  a_sel_refused: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    wr_snap && !sel_ok |=> $stable(o_snap_sel))
    else $error("reserved channel code taken");
  a_sel_taken: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    wr_snap && sel_ok |=> o_snap_sel == $past(new_sel))
    else $error("channel code not stored");
  // nvm port checks
  a_first_byte: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    start_go |=> o_nvm_data == $past(i_fault_reg))
    else $error("first capture byte wrong");
  a_nvm_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_nvm_req && !i_nvm_ack |=> o_nvm_req && $stable(o_nvm_addr) && $stable(o_nvm_data))
    else $error("nvm request moved before ack");
  a_adc_area: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_nvm_req && idx_r == MSCFL_NVM_SPLIT |-> o_nvm_addr == MSCFL_NVM_ADC)
    else $error("first adc byte address wrong");
endmodule

// file: test/mscfl_nvm_model.sv
// behavioural nonvolatile store taking capture bytes over req/ack
`timescale 1ns/10ps
module mscfl_nvm_model (
  input wire logic i_mclk, // system clock
  input wire logic i_req, // byte write request
  input wire logic [7:0] i_addr, // location
  input wire logic [7:0] i_data, // byte
  input wire logic [3:0] i_wait, // ack delay in cycles
  output logic o_ack // byte taken pulse
);
  logic [7:0] mem [0:255]; // stored bytes
  int count = 0; // bytes taken
  initial o_ack = 1'b0;
  ////////////////////////////////////////////////////////////////
  // wait, ack one cycle, store at the ack edge, skip the stale cycle
  always begin
    @(posedge i_mclk);
    if (i_req === 1'b1) begin
      repeat (i_wait) @(posedge i_mclk);
      #1 o_ack = 1'b1;
      @(posedge i_mclk);
      mem[i_addr] = i_data;
      count++;
      #1 o_ack = 1'b0;
      @(posedge i_mclk);
    end
  end
endmodule

// file: test/meter_snapshot_faultlog_ctrl_tb_top.sv
// register-level bench for meter, snapshot and capture control
`timescale 1ns/10ps
module meter_snapshot_faultlog_ctrl_tb_top;
  import mscfl_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0; // clock, reset, strobes
  logic alert_ev = 1'b0, locked = 1'b0, pwr_valid = 1'b0, fault_trig = 1'b0; // events
  logic nvm_ack, snap_mode, nvm_req, log_alert; // outputs
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, fault_reg = 8'h5A; // bus and fault
  logic [7:0] reg_rdata, nvm_addr, nvm_data, base; // outputs, snapshot of count
  logic [39:0] alarm_log = 40'h1122334455; // alarm bytes
  logic [23:0] pwr_value = 24'h000000, sense_msb = 24'hA1B2C3, volt_msb = 24'hD4E5F6;
  logic [3:0] snap_sel, nvm_wait = 4'h0, prev; // channel, ack delay
  int fails = 0, cmp_count = 0, alert_cnt = 0, i; // counters
  always #5 clk = ~clk;
  mscfl_ctrl u_mscfl_ctrl (.i_mclk(clk), .i_rst_n(rst_n), .i_reg_addr(reg_addr),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_alert_event(alert_ev), .i_nvm_factory_locked(locked), .i_pwr_valid(pwr_valid),
    .i_pwr_value(pwr_value), .i_fault_trigger(fault_trig), .i_fault_reg(fault_reg),
    .i_alarm_log(alarm_log), .i_sense_msb(sense_msb), .i_power_calc_voltage_msb(volt_msb),
    .o_snap_sel(snap_sel), .o_snap_mode(snap_mode), .o_nvm_req(nvm_req),
    .o_nvm_addr(nvm_addr), .o_nvm_data(nvm_data), .i_nvm_ack(nvm_ack),
    .o_log_alert(log_alert));
  mscfl_nvm_model u_mscfl_nvm_model (.i_mclk(clk), .i_req(nvm_req), .i_addr(nvm_addr),
    .i_data(nvm_data), .i_wait(nvm_wait), .o_ack(nvm_ack));
  ////////////////////////////////////////////////////////////////
  // count completion alert pulses
  always @(posedge clk) begin
    if (log_alert === 1'b1) alert_cnt++;
  end
  // verdict and end of run
  task conclude;
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // compare seen against expected
  task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  // one clock, inputs move 1 ns later
  task tick;
    @(posedge clk);
    #1;
  endtask
  // register byte write
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
    tick;
  endtask
  // register read, data checked 1 ns after the read edge
  task rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    chk(reg_rdata, exp, "read");
    tick;
  endtask
  // one power result
  task pwr(input logic [23:0] v);
    pwr_value = v;
    pwr_valid = 1'b1;
    tick;
    pwr_valid = 1'b0;
    tick;
  endtask
  // one fault pulse
  task trig;
    fault_trig = 1'b1;
    tick;
    fault_trig = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(MSCFL_ADDR_METER, 8'h00);
    rd(MSCFL_ADDR_SNAP, 8'h00);
    rd(MSCFL_ADDR_LOG, 8'h00);
    rd(8'h91, 8'h00);
    // lock bit read-only, reserved bits zero
    locked = 1'b1;
    wr(MSCFL_ADDR_METER, 8'h07);
    rd(MSCFL_ADDR_METER, 8'h04);
    locked = 1'b0;
    wr(MSCFL_ADDR_METER, 8'h04);
    rd(MSCFL_ADDR_METER, 8'h00);
    // every channel code, reserved codes refused
    prev = 4'h0;
    for (i = 0; i < 16; i++) begin
      wr(MSCFL_ADDR_SNAP, {i[3:0], 4'hF});
      if (i != 10 && i != 11) prev = i[3:0];
      chk({4'h0, snap_sel}, {4'h0, prev}, "channel");
      chk({7'h00, snap_mode}, 8'h01, "mode");
      rd(MSCFL_ADDR_SNAP, {prev, 4'h8});
    end
    wr(MSCFL_ADDR_SNAP, 8'h00);
    chk({7'h00, snap_mode}, 8'h00, "mode");
    // accumulate, freeze, clear
    pwr(24'h000005);
    pwr(24'h000005);
    pwr(24'h000005);
    rd(8'h7F, 8'h0F);
    rd(8'h83, 8'h03);
    wr(MSCFL_ADDR_METER, 8'h40);
    pwr(24'h000005);
    rd(8'h7F, 8'h0F);
    rd(8'h83, 8'h03);
    wr(MSCFL_ADDR_METER, 8'h80);
    pwr(24'h000005);
    rd(8'h7F, 8'h00);
    rd(8'h83, 8'h00);
    wr(MSCFL_ADDR_METER, 8'h00);
    // both counts wrap on one result
    for (i = 0; i < 10; i++) wr(MSCFL_ADDR_ENERGY + i[7:0], 8'hFF);
    pwr(24'h000001);
    for (i = 0; i < 10; i++) rd(MSCFL_ADDR_ENERGY + i[7:0], 8'h00);
    rd(MSCFL_ADDR_METER, 8'h30);
    wr(MSCFL_ADDR_METER, 8'h30);
    rd(MSCFL_ADDR_METER, 8'h30);
    wr(MSCFL_ADDR_METER, 8'h00);
    rd(MSCFL_ADDR_METER, 8'h00);
    // alert latch
    alert_ev = 1'b1;
    tick;
    alert_ev = 1'b0;
    tick;
    rd(MSCFL_ADDR_METER, 8'h08);
    wr(MSCFL_ADDR_METER, 8'h08);
    rd(MSCFL_ADDR_METER, 8'h08);
    wr(MSCFL_ADDR_METER, 8'h00);
    rd(MSCFL_ADDR_METER, 8'h00);
    // capture with completion alert, prompt store
    wr(MSCFL_ADDR_LOG, 8'h88);
    trig;
    for (i = 0; i < 600 && alert_cnt == 0; i++) tick;
    if (alert_cnt == 0) begin
      fails++;
      conclude;
    end
    tick;
    chk(u_mscfl_nvm_model.count[7:0], 8'h0C, "bytes");
    chk(u_mscfl_nvm_model.mem[8'hA4], fault_reg, "fault");
    for (i = 0; i < 5; i++) chk(u_mscfl_nvm_model.mem[8'hA5 + i], alarm_log[39-8*i -: 8], "alarm");
    for (i = 0; i < 3; i++) chk(u_mscfl_nvm_model.mem[8'hE1 + i], sense_msb[23-8*i -: 8], "sense");
    for (i = 0; i < 3; i++) chk(u_mscfl_nvm_model.mem[8'hE4 + i], volt_msb[23-8*i -: 8], "volt");
    rd(MSCFL_ADDR_LOG, 8'hB8);
    rd(MSCFL_ADDR_METER, 8'h08);
    // no second capture while flags stand, no clear without permit
    trig;
    repeat (20) tick;
    chk(u_mscfl_nvm_model.count[7:0], 8'h0C, "bytes");
    wr(MSCFL_ADDR_LOG, 8'h88);
    rd(MSCFL_ADDR_LOG, 8'hB8);
    wr(MSCFL_ADDR_LOG, 8'hC8);
    rd(MSCFL_ADDR_LOG, 8'hF8);
    wr(MSCFL_ADDR_LOG, 8'hC8);
    rd(MSCFL_ADDR_LOG, 8'hC8);
    wr(MSCFL_ADDR_LOG, 8'hB0);
    rd(MSCFL_ADDR_LOG, 8'h80);
    // second capture, no alert, slow store
    nvm_wait = 4'h3;
    fault_reg = 8'hA5;
    base = u_mscfl_nvm_model.count[7:0];
    trig;
    for (i = 0; i < 900 && u_mscfl_nvm_model.count[7:0] != base + 8'h0C; i++) tick;
    if (u_mscfl_nvm_model.count[7:0] != base + 8'h0C) begin
      fails++;
      conclude;
    end
    repeat (4) tick;
    chk(u_mscfl_nvm_model.mem[8'hA4], 8'hA5, "fault");
    chk(alert_cnt[7:0], 8'h01, "alert");
    rd(MSCFL_ADDR_LOG, 8'hB0);
    wr(MSCFL_ADDR_LOG, 8'h00);
    rd(MSCFL_ADDR_LOG, 8'h30);
    // flags cleared but capture disarmed: fault is ignored
    wr(MSCFL_ADDR_LOG, 8'h40);
    wr(MSCFL_ADDR_LOG, 8'h40);
    rd(MSCFL_ADDR_LOG, 8'h40);
    base = u_mscfl_nvm_model.count[7:0];
    trig;
    repeat (20) tick;
    chk(u_mscfl_nvm_model.count[7:0], base, "bytes");
    rd(MSCFL_ADDR_LOG, 8'h40);
    conclude;
  end
endmodule
